// ---- logic/cbd_exec.sv ----
// Execution datapath: compare-skip-if-less, decimal adjust, decrement
// How it works
// - Compare takes 1, skip 2, two-word skip 3
// - Unsigned f<acc discards next instruction as nop
// - Compare decoded from 0110 000a ffff ffff
// - Low nibble +6 if >9 or digit carry
// - High nibble +digit carry, +6 if that sum >9 or carry, carry updated
// - Decrement to acc when d=0, else file
// - a=0 access bank, a=1 bank select
// - Extended mode, a=0, f<=95 indexed offset
// - Decrement updates carry, digit carry, negative, overflow, zero
module cbd_exec
  import cbd_pkg::*;
(
  input  wire logic               sys_clk,       // Core instruction clock
  input  wire logic               sys_rst,       // Synchronous reset, high
  input  wire cbd_pkg::cbd_instr_t instr,        // Instruction in execute
  input  wire logic [7:0]         file_rdata,    // Operand read from data memory
  input  wire logic [3:0]         bank_select_register, // Upper address bits
  input  wire logic [11:0]        index_base,    // Index pointer for offset mode
  input  wire logic               ext_set_en,    // Extended instruction set on
  output logic [11:0]             file_raddr,    // Operand address, combinational
  output logic                    file_we,       // File write strobe
  output logic [11:0]             file_waddr,    // File write address
  output logic [7:0]              file_wdata,    // File write data
  output logic [7:0]              accumulator_register, // Accumulator
  output logic [7:0]              status_flags,  // Negative, overflow, zero, digit carry, carry
  output logic                    exec_nop       // Current slot runs as a no-op
);
  import cbd_pkg::*;

  cbd_state_t s_q, s_d;

  function automatic logic [11:0] eff_addr(input logic [15:0] w, input logic [3:0] bank,
                                           input logic ext, input logic [11:0] ib);
    logic [7:0] f;
    f = w[7:0];
    if (w[A_BIT]) eff_addr = {bank, f};
    else if (ext && f <= IDX_LIMIT) eff_addr = ib + {4'h0, f};
    else if (f < ACC_SPLIT) eff_addr = {4'h0, f};
    else eff_addr = {ACC_HI_BANK, f};
  endfunction : eff_addr

  logic is_cmp, is_dec, is_adj, live;
  logic [3:0] lo, hi;
  logic       lo_fix, hi_fix;
  logic [8:0] dec_full;
  logic [7:0] dec_res;

  assign live   = instr.valid && s_q.phase == CBD_RUN;
  assign is_cmp = live && instr.word[15:9] == OPC_CMP_LT;
  assign is_dec = live && instr.word[15:10] == OPC_DEC;
  assign is_adj = live && instr.word == OPC_ADJ;
  assign file_raddr = eff_addr(instr.word, bank_select_register, ext_set_en, index_base);
  assign exec_nop = s_q.phase != CBD_RUN;

  always_comb begin
    s_d = s_q;
    s_d.fwr = 1'h0;
    lo_fix = 1'h0;
    hi_fix = 1'h0;
    lo = s_q.acc[3:0];
    hi = s_q.acc[7:4];
    dec_full = {1'h0, file_rdata} + 9'h0FF;                              // f + ~1 + 1
    dec_res = dec_full[7:0];
    unique case (s_q.phase)
      CBD_SKIP1: s_d.phase = CBD_RUN;
      CBD_SKIP2: s_d.phase = CBD_SKIP1;
      CBD_RUN: begin
        if (is_cmp && file_rdata < s_q.acc) begin
          s_d.phase = instr.next_two ? CBD_SKIP2 : CBD_SKIP1;
        end
        if (is_adj) begin
          lo_fix = s_q.acc[3:0] > BCD_MAX || s_q.status[FLG_DIG];
          lo = lo_fix ? s_q.acc[3:0] + BCD_FIX : s_q.acc[3:0];
          hi_fix = ({1'h0, s_q.acc[7:4]} + {4'h0, s_q.status[FLG_DIG]}) > {1'h0, BCD_MAX}
                   || s_q.status[FLG_C];
          // Only the flag feeds the high nibble; the low fix does not ripple
          hi = s_q.acc[7:4] + {3'h0, s_q.status[FLG_DIG]} + (hi_fix ? BCD_FIX : 4'h0);
          s_d.acc = {hi, lo};
          s_d.status[FLG_C] = hi_fix;
        end
        if (is_dec) begin
          s_d.status[FLG_C]   = dec_full[8];
          s_d.status[FLG_DIG] = file_rdata[3:0] != 4'h0;
          s_d.status[FLG_N]   = dec_res[7];
          s_d.status[FLG_OVF] = file_rdata == 8'h80;
          s_d.status[FLG_Z]  = dec_res == 8'h00;
          if (instr.word[DA_BIT]) begin
            s_d.fwr = 1'h1;
            s_d.faddr = file_raddr;
            s_d.fdata = dec_res;
          end else begin
            s_d.acc = dec_res;
          end
        end
      end
      default: s_d.phase = CBD_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '{phase: CBD_RUN, acc: ACC_RST, status: STATUS_RST, fwr: 1'h0,
               faddr: 12'h000, fdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign file_we = s_q.fwr;
  assign file_waddr = s_q.faddr;
  assign file_wdata = s_q.fdata;
  assign accumulator_register = s_q.acc;
  assign status_flags = s_q.status;

  sequence s_one_nop;
    exec_nop ##1 !exec_nop;
  endsequence
  property p_skip_one;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_cmp && file_rdata < s_q.acc && !instr.next_two) |=> s_one_nop;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip not one slot");
  sequence s_two_nops;
    exec_nop [*2] ##1 !exec_nop;
  endsequence
  property p_skip_two;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_cmp && file_rdata < s_q.acc && instr.next_two) |=> s_two_nops;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong");
  property p_no_skip;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_cmp && file_rdata >= s_q.acc) |=> !exec_nop;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("spurious skip");
  property p_dec_file;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_dec && instr.word[DA_BIT]) |=> file_we && file_wdata == $past(file_rdata) - 8'h01;
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("decrement write wrong");
  property p_dec_acc;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_dec && !instr.word[DA_BIT]) |=> !file_we
        && accumulator_register == $past(file_rdata) - 8'h01;
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to acc wrong");
  property p_bank;
    @(posedge sys_clk) disable iff (sys_rst)
      (instr.valid && instr.word[A_BIT]) |-> file_raddr == {bank_select_register, instr.word[7:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select address wrong");
  property p_index;
    @(posedge sys_clk) disable iff (sys_rst)
      (instr.valid && !instr.word[A_BIT] && ext_set_en && instr.word[7:0] <= IDX_LIMIT)
        |-> file_raddr == index_base + {4'h0, instr.word[7:0]};
  endproperty
  a_index: assert property (p_index) else $error("indexed offset address wrong");
  property p_dec_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      is_dec |=> status_flags[FLG_Z] == ($past(file_rdata) == 8'h01);
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("zero flag wrong");
  property p_adj_low;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_adj && !status_flags[FLG_DIG] && accumulator_register[3:0] <= BCD_MAX)
        |=> accumulator_register[3:0] == $past(accumulator_register[3:0]);
  endproperty
  a_adj_low: assert property (p_adj_low) else $error("low nibble changed");
  property p_adj_low_fix;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_adj && (accumulator_register[3:0] > BCD_MAX || status_flags[FLG_DIG]))
        |=> accumulator_register[3:0] == $past(accumulator_register[3:0]) + BCD_FIX;
  endproperty
  a_adj_low_fix: assert property (p_adj_low_fix) else $error("low nibble not fixed");
  // Five-bit sum, so 0xF plus digit carry still counts as over nine
  property p_adj_high_fix;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_adj && (status_flags[FLG_C] || ({1'h0, accumulator_register[7:4]}
        + {4'h0, status_flags[FLG_DIG]}) > {1'h0, BCD_MAX}))
        |=> status_flags[FLG_C] && accumulator_register[7:4] ==
          $past(accumulator_register[7:4]) + $past(status_flags[FLG_DIG]) + BCD_FIX;
  endproperty
  a_adj_high_fix: assert property (p_adj_high_fix) else $error("high nibble not fixed");
  property p_adj_high_plain;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_adj && !status_flags[FLG_C] && ({1'h0, accumulator_register[7:4]}
        + {4'h0, status_flags[FLG_DIG]}) <= {1'h0, BCD_MAX})
        |=> !status_flags[FLG_C] && accumulator_register[7:4] ==
          $past(accumulator_register[7:4]) + $past(status_flags[FLG_DIG]);
  endproperty
  a_adj_high_plain: assert property (p_adj_high_plain) else $error("high nibble wrong");
  property p_dec_carry;
    @(posedge sys_clk) disable iff (sys_rst)
      is_dec |=> status_flags[FLG_C] == ($past(file_rdata) != 8'h00)
        && status_flags[FLG_OVF] == ($past(file_rdata) == 8'h80);
  endproperty
  a_dec_carry: assert property (p_dec_carry) else $error("carry or overflow wrong");
  property p_dec_digit;
    @(posedge sys_clk) disable iff (sys_rst)
      is_dec |=> status_flags[FLG_DIG] == ($past(file_rdata[3:0]) != 4'h0);
  endproperty
  a_dec_digit: assert property (p_dec_digit) else $error("digit carry wrong");
  property p_dec_neg;
    @(posedge sys_clk) disable iff (sys_rst)
      is_dec |=> status_flags[FLG_N]
        == ($past(file_rdata) > 8'h80 || $past(file_rdata) == 8'h00);
  endproperty
  a_dec_neg: assert property (p_dec_neg) else $error("negative flag wrong");
  property p_no_stray_write;
    @(posedge sys_clk) disable iff (sys_rst)
      !(is_dec && instr.word[DA_BIT]) |=> !file_we;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("stray file write");
  // A word offered in a no-op slot must leave no trace
  property p_nop_slot;
    @(posedge sys_clk) disable iff (sys_rst)
      exec_nop |=> !file_we && $stable(accumulator_register) && $stable(status_flags);
  endproperty
  a_nop_slot: assert property (p_nop_slot) else $error("no-op slot changed state");
  property p_other_op;
    @(posedge sys_clk) disable iff (sys_rst)
      (instr.valid && !exec_nop && instr.word[15:9] != OPC_CMP_LT) |=> !exec_nop;
  endproperty
  a_other_op: assert property (p_other_op) else $error("skip on other opcode");
  property p_spare_bits;
    @(posedge sys_clk) disable iff (sys_rst)
      status_flags[7:5] == 3'h0;
  endproperty
  a_spare_bits: assert property (p_spare_bits) else $error("spare status bits set");
  property p_reset;
    @(posedge sys_clk)
      sys_rst |=> accumulator_register == ACC_RST && status_flags == STATUS_RST
        && !file_we && !exec_nop;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : cbd_exec

// ---- logic/cbd_pkg.sv ----
// Package for the compare / decimal adjust / decrement execution datapath
package cbd_pkg;
  localparam logic [6:0] OPC_CMP_LT = 7'h30;    // 0110 000a
  localparam logic [5:0] OPC_DEC    = 6'h01;    // 0000 01da
  localparam logic [15:0] OPC_ADJ   = 16'h0007;
  localparam logic [7:0] IDX_LIMIT  = 8'h5F;    // 95
  localparam logic [7:0] ACC_SPLIT  = 8'h60;    // Access bank upper half starts here
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [3:0] BCD_FIX    = 4'h6;
  localparam int DA_BIT  = 9;
  localparam int A_BIT   = 8;
  localparam int FLG_C   = 0;
  localparam int FLG_DIG = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_N   = 4;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] ACC_RST    = 8'h00;

  typedef enum logic [1:0] {CBD_RUN, CBD_SKIP1, CBD_SKIP2} cbd_phase_t;

  typedef struct packed {
    logic       valid;      // Instruction word valid this cycle
    logic [15:0] word;      // Instruction word
    logic       next_two;   // Following fetched instruction is two words
  } cbd_instr_t;

  typedef struct packed {
    cbd_phase_t phase;
    logic [7:0] acc;
    logic [7:0] status;
    logic       fwr;
    logic [11:0] faddr;
    logic [7:0] fdata;
  } cbd_state_t;
endpackage : cbd_pkg

// ---- verif/test_compare_bcd_decrement_exec.sv ----
// Self-checking bench for the compare / decimal adjust / decrement datapath
module test_compare_bcd_decrement_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import cbd_pkg::*;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  cbd_instr_t  instr = '0;
  logic [7:0]  file_rdata = 8'h00;
  logic [3:0]  bank_select_register = 4'h5;
  logic [11:0] index_base = 12'h300;
  logic        ext_set_en = 1'h0;
  logic [11:0] file_raddr, file_waddr, ra;
  logic        file_we, exec_nop;
  logic [7:0]  file_wdata, accumulator_register, status_flags;
  int          fails = 0, checked = 0, cyc = 0;
  cbd_exec i_cbd_exec (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr),
    .file_rdata(file_rdata), .bank_select_register(bank_select_register),
    .index_base(index_base), .ext_set_en(ext_set_en), .file_raddr(file_raddr),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .accumulator_register(accumulator_register), .status_flags(status_flags),
    .exec_nop(exec_nop));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] dw(input logic d, input logic a, input logic [7:0] f);
    return {OPC_DEC, d, a, f};
  endfunction : dw
  // One instruction, one slot; address sampled while the word is valid
  task automatic op(input logic [15:0] w, input logic [7:0] rd, input logic nt, input logic x);
    @(posedge sys_clk);
    instr <= '{1'h1, w, nt};
    file_rdata <= rd;
    ext_set_en <= x;
    #1 ra = file_raddr;
    @(posedge sys_clk);
    instr.valid <= 1'h0;
    #1;
  endtask : op
  task automatic t_dec;
    op(OPC_ADJ, 8'h00, 1'h0, 1'h0);
    `CHK({accumulator_register, status_flags}, 16'h0000)
    op(dw(1'h0, 1'h0, 8'h10), 8'h36, 1'h0, 1'h0);
    `CHK(accumulator_register, 8'h35)
    `CHK(status_flags, 8'h03)
    `CHK(ra, 12'h010)
    op(dw(1'h1, 1'h1, 8'h20), 8'h01, 1'h0, 1'h0);
    `CHK({file_we, file_waddr, file_wdata}, {1'h1, 12'h520, 8'h00})
    `CHK(status_flags, 8'h07)
    `CHK(ra, 12'h520)
    @(posedge sys_clk);
    #1 `CHK(file_we, 1'h0)
    op(dw(1'h0, 1'h0, 8'h70), 8'h00, 1'h0, 1'h0);
    `CHK({accumulator_register, status_flags}, 16'hFF10)
    `CHK(ra, 12'hF70)
    op(dw(1'h0, 1'h0, 8'h5F), 8'h80, 1'h0, 1'h1);
    `CHK({accumulator_register, status_flags}, 16'h7F09)
    `CHK(ra, 12'h35F)
    op(dw(1'h0, 1'h0, 8'h60), 8'h00, 1'h0, 1'h1);
    `CHK(ra, 12'hF60)
    $display("decrement test done");
  endtask : t_dec
  // Entry: acc FF, carry and digit carry clear
  // Low-nibble fix does not ripple into the high nibble
  task automatic t_adj;
    op(OPC_ADJ, 8'h00, 1'h0, 1'h0);
    `CHK({accumulator_register, status_flags}, 16'h5511)
    op(OPC_ADJ, 8'h00, 1'h0, 1'h0);
    `CHK(accumulator_register, 8'hB5)
    op(dw(1'h0, 1'h0, 8'h10), 8'h01, 1'h0, 1'h0);
    op(OPC_ADJ, 8'h00, 1'h0, 1'h0);
    `CHK(accumulator_register, 8'h76)
    $display("decimal adjust test done");
  endtask : t_adj
  // Entry: acc 76
  task automatic t_cmp;
    @(posedge sys_clk);
    instr <= '{1'h1, {OPC_CMP_LT, 1'h0, 8'h10}, 1'h0};
    file_rdata <= 8'h65;
    @(posedge sys_clk);
    instr <= '{1'h1, dw(1'h0, 1'h0, 8'h10), 1'h0};
    file_rdata <= 8'h01;
    #1 `CHK(exec_nop, 1'h1)
    @(posedge sys_clk);
    instr.valid <= 1'h0;
    #1 `CHK({exec_nop, accumulator_register}, 9'h076)
    op({OPC_CMP_LT, 1'h1, 8'h20}, 8'h00, 1'h1, 1'h0);
    `CHK(exec_nop, 1'h1)
    @(posedge sys_clk);
    #1 `CHK(exec_nop, 1'h1)
    @(posedge sys_clk);
    #1 `CHK(exec_nop, 1'h0)
    op({OPC_CMP_LT, 1'h0, 8'h10}, 8'h76, 1'h0, 1'h0);
    `CHK(exec_nop, 1'h0)
    op(16'h6410, 8'h00, 1'h0, 1'h0);
    `CHK(exec_nop, 1'h0)
    $display("compare test done");
  endtask : t_cmp
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Whole run is under 100 cycles; a hang stops here
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    #1 `CHK({accumulator_register, status_flags, file_we, exec_nop}, 18'h0)
    t_dec();
    t_adj();
    t_cmp();
    report_and_stop();
  end
endmodule : test_compare_bcd_decrement_exec
